/* File: src/smon_selector.sv */
// monitor slot selector for the motion network monitor words
// Functional notes
// (RL1) code 0: filtered command position
// (RL2) code 5: unfiltered command position
// (RL3) code 3: machine-frame feedback position
// (RL4) code 4: latched machine-frame feedback position
// (RL5) feedback positions exclude backlash compensation
// (RL6) code 6: target position
// (RL7) codes E/F follow their own selects
// (RL8) 0003h/0004h: deviation low/high words
// (RL9) 000Ah/000Bh: encoder count low/high words
// (RL10) 0017h/0018h/001Ch/001Dh: speed, deviation, counters
// (RL11) 0080h: previous latched feedback position
// (RL12) compensating: shaft minus amount, else shaft
// (RL13) codes 1/2 return internal command position/deviation; other unlisted codes or selections return zero
module smon_selector
    import smon_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cfg_we,
    input wire logic [SLOT_N-1:0][CODE_W-1:0] i_slot_code,
    input wire logic [SEL_W-1:0] i_option_monitor_a_select,
    input wire logic [SEL_W-1:0] i_option_monitor_b_select,
    input wire logic [POS_W-1:0] i_cmd_pos_filtered,
    input wire logic [POS_W-1:0] i_cmd_pos_internal,
    input wire logic [POS_W-1:0] i_cmd_pos_unfiltered,
    input wire logic [POS_W-1:0] i_target_pos,
    input wire logic [WIDE_W-1:0] i_pos_deviation,
    input wire logic [POS_W-1:0] i_shaft_pos,
    input wire logic [POS_W-1:0] i_backlash_amount,
    input wire logic i_backlash_active,
    input wire logic [WIDE_W-1:0] i_pg_count,
    input wire logic [POS_W-1:0] i_pulse_speed,
    input wire logic [POS_W-1:0] i_cmd_pulse_cnt,
    input wire logic [POS_W-1:0] i_fb_pulse_cnt,
    input wire logic i_latch_pin,
    input wire logic i_latch_ack,
    output logic [SLOT_N-1:0][POS_W-1:0] o_monitor,
    output logic [POS_W-1:0] o_option_monitor_a,
    output logic [POS_W-1:0] o_option_monitor_b,
    output logic o_latch_done,
    output logic o_backlash_applied
);

    // ========================================================
    // configuration registers
    logic [SLOT_N-1:0][CODE_W-1:0] code_reg;
    logic [SLOT_N-1:0][CODE_W-1:0] code_next;
    logic [SEL_W-1:0] sel_a_reg;
    logic [SEL_W-1:0] sel_a_next;
    logic [SEL_W-1:0] sel_b_reg;
    logic [SEL_W-1:0] sel_b_next;

    always_comb begin
        code_next = code_reg;
        sel_a_next = sel_a_reg;
        sel_b_next = sel_b_reg;
        if (i_cfg_we) begin
            code_next = i_slot_code;
            sel_a_next = i_option_monitor_a_select; // RL7
            sel_b_next = i_option_monitor_b_select; // RL7
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            code_reg <= {SLOT_N{RST_CODE}};
            sel_a_reg <= RST_SEL;
            sel_b_reg <= RST_SEL;
        end else begin
            code_reg <= code_next;
            sel_a_reg <= sel_a_next;
            sel_b_reg <= sel_b_next;
        end
    end

    // ========================================================
    // feedback position with backlash removed
    logic [POS_W-1:0] machine_feedback_pos;

    smon_fb_pos u_fb_pos (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_shaft_pos(i_shaft_pos),
        .i_backlash_amount(i_backlash_amount),
        .i_backlash_active(i_backlash_active),
        .o_machine_feedback_pos(machine_feedback_pos),
        .o_backlash_applied(o_backlash_applied)
    );

    // ========================================================
    // latch pin synchroniser
    logic latch_s1_reg;
    logic latch_s2_reg;
    logic latch_s3_reg;
    logic latch_s1_next;
    logic latch_s2_next;
    logic latch_s3_next;
    logic latch_edge;

    // two stages before any logic reads the pin
    always_comb begin
        latch_s1_next = i_latch_pin;
        latch_s2_next = latch_s1_reg;
        latch_s3_next = latch_s2_reg;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            latch_s1_reg <= 1'b0;
            latch_s2_reg <= 1'b0;
            latch_s3_reg <= 1'b0;
        end else begin
            latch_s1_reg <= latch_s1_next;
            latch_s2_reg <= latch_s2_next;
            latch_s3_reg <= latch_s3_next;
        end
    end

    // ========================================================
    // rising edge of the synchronised pin
    assign latch_edge = latch_s2_reg & ~latch_s3_reg;

    // ========================================================
    // latched feedback position and its previous value
    logic [POS_W-1:0] latched_feedback_pos_reg;
    logic [POS_W-1:0] latched_feedback_pos_next;
    logic [POS_W-1:0] prev_latched_reg;
    logic [POS_W-1:0] prev_latched_next;

    // old latch shifts into the previous value
    always_comb begin
        latched_feedback_pos_next = latched_feedback_pos_reg;
        prev_latched_next = prev_latched_reg;
        if (latch_edge) begin
            latched_feedback_pos_next = machine_feedback_pos; // RL4 RL5
            prev_latched_next = latched_feedback_pos_reg; // RL11
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            latched_feedback_pos_reg <= RST_POS;
            prev_latched_reg <= RST_POS;
        end else begin
            latched_feedback_pos_reg <= latched_feedback_pos_next;
            prev_latched_reg <= prev_latched_next;
        end
    end

    // ========================================================
    // latch done flag
    smon_latch_state_t latch_state_reg;
    smon_latch_state_t latch_state_next;

    always_comb begin
        latch_state_next = latch_state_reg;
        case (latch_state_reg)
            SMON_LATCH_IDLE: begin
                if (latch_edge) begin
                    latch_state_next = SMON_LATCH_HELD;
                end
            end
            SMON_LATCH_HELD: begin
                // a new edge in the ack cycle keeps the flag set
                if (i_latch_ack && !latch_edge) begin
                    latch_state_next = SMON_LATCH_IDLE;
                end
            end
            default: begin
                latch_state_next = SMON_LATCH_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            latch_state_reg <= SMON_LATCH_IDLE;
        end else begin
            latch_state_reg <= latch_state_next;
        end
    end

    assign o_latch_done = (latch_state_reg == SMON_LATCH_HELD);

    // ========================================================
    // option monitor quantities
    smon_quant_if quant ();

    assign quant.pos_deviation = i_pos_deviation;
    assign quant.pg_count = i_pg_count;
    assign quant.pulse_speed = i_pulse_speed;
    assign quant.cmd_pulse_cnt = i_cmd_pulse_cnt;
    assign quant.fb_pulse_cnt = i_fb_pulse_cnt;
    assign quant.prev_latched_pos = prev_latched_reg;

    logic [POS_W-1:0] opt_a_value;
    logic [POS_W-1:0] opt_b_value;

    smon_opt_mux u_opt_a (
        .i_select(sel_a_reg),
        .q(quant),
        .o_value(opt_a_value)
    );

    smon_opt_mux u_opt_b (
        .i_select(sel_b_reg),
        .q(quant),
        .o_value(opt_b_value)
    );

    // ========================================================
    // monitor code decode
    function automatic logic [POS_W-1:0] slot_value(
        input logic [CODE_W-1:0] code,
        input logic [POS_W-1:0] cmd_filt,
        input logic [POS_W-1:0] cmd_int,
        input logic [POS_W-1:0] dev,
        input logic [POS_W-1:0] mach_fb,
        input logic [POS_W-1:0] latch_fb,
        input logic [POS_W-1:0] cmd_unfilt,
        input logic [POS_W-1:0] target,
        input logic [POS_W-1:0] opt_a,
        input logic [POS_W-1:0] opt_b
    );
        logic [POS_W-1:0] r;
        case (code)
            CODE_CMD_FILT: r = cmd_filt; // RL1
            CODE_CMD_INT: r = cmd_int;
            CODE_DEV: r = dev;
            CODE_MACH_FB: r = mach_fb; // RL3
            CODE_LATCH_FB: r = latch_fb; // RL4
            CODE_CMD_UNFILT: r = cmd_unfilt; // RL2
            CODE_TARGET: r = target; // RL6
            CODE_OPT_A: r = opt_a; // RL7
            CODE_OPT_B: r = opt_b; // RL7
            default: r = RST_POS; // RL13
        endcase
        return r;
    endfunction

    // ========================================================
    // monitor slots
    logic [SLOT_N-1:0][POS_W-1:0] monitor_reg;
    logic [SLOT_N-1:0][POS_W-1:0] monitor_next;

    genvar s;
    generate
        for (s = 0; s < SLOT_N; s = s + 1) begin : g_slot
            always_comb begin
                monitor_next[s] = slot_value(
                    code_reg[s],
                    i_cmd_pos_filtered,
                    i_cmd_pos_internal,
                    i_pos_deviation[POS_W-1:0],
                    machine_feedback_pos,
                    latched_feedback_pos_reg,
                    i_cmd_pos_unfiltered,
                    i_target_pos,
                    opt_a_value,
                    opt_b_value
                );
            end

            always_ff @(posedge i_ref_clk or posedge i_rst) begin
                if (i_rst) begin
                    monitor_reg[s] <= RST_POS;
                end else begin
                    monitor_reg[s] <= monitor_next[s];
                end
            end
        end
    endgenerate

    // ========================================================
    // option monitor outputs
    logic [POS_W-1:0] opt_a_reg;
    logic [POS_W-1:0] opt_a_next;
    logic [POS_W-1:0] opt_b_reg;
    logic [POS_W-1:0] opt_b_next;

    always_comb begin
        opt_a_next = opt_a_value; // RL7
        opt_b_next = opt_b_value; // RL7
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            opt_a_reg <= RST_POS;
            opt_b_reg <= RST_POS;
        end else begin
            opt_a_reg <= opt_a_next;
            opt_b_reg <= opt_b_next;
        end
    end

    assign o_monitor = monitor_reg;
    assign o_option_monitor_a = opt_a_reg;
    assign o_option_monitor_b = opt_b_reg;

endmodule // smon_selector

/* File: inc/smon_pkg.sv */
// constants shared by the servo monitor selector
package smon_pkg;

    // ========================================================
    // widths
    localparam int POS_W = 32;
    localparam int WIDE_W = 64;
    localparam int CODE_W = 4;
    localparam int SEL_W = 16;
    localparam int SLOT_N = 4;

    // ========================================================
    // monitor codes
    localparam logic [CODE_W-1:0] CODE_CMD_FILT = 4'h0;
    localparam logic [CODE_W-1:0] CODE_CMD_INT = 4'h1;
    localparam logic [CODE_W-1:0] CODE_DEV = 4'h2;
    localparam logic [CODE_W-1:0] CODE_MACH_FB = 4'h3;
    localparam logic [CODE_W-1:0] CODE_LATCH_FB = 4'h4;
    localparam logic [CODE_W-1:0] CODE_CMD_UNFILT = 4'h5;
    localparam logic [CODE_W-1:0] CODE_TARGET = 4'h6;
    localparam logic [CODE_W-1:0] CODE_OPT_A = 4'hE;
    localparam logic [CODE_W-1:0] CODE_OPT_B = 4'hF;

    // ========================================================
    // option monitor selections
    localparam logic [SEL_W-1:0] SEL_DEV_LO = 16'h0003;
    localparam logic [SEL_W-1:0] SEL_DEV_HI = 16'h0004;
    localparam logic [SEL_W-1:0] SEL_PG_LO = 16'h000A;
    localparam logic [SEL_W-1:0] SEL_PG_HI = 16'h000B;
    localparam logic [SEL_W-1:0] SEL_PULSE_SPD = 16'h0017;
    localparam logic [SEL_W-1:0] SEL_DEV_32 = 16'h0018;
    localparam logic [SEL_W-1:0] SEL_CMD_CNT = 16'h001C;
    localparam logic [SEL_W-1:0] SEL_FB_CNT = 16'h001D;
    localparam logic [SEL_W-1:0] SEL_PREV_LATCH = 16'h0080;

    // ========================================================
    // reset values
    localparam logic [CODE_W-1:0] RST_CODE = 4'h0;
    localparam logic [SEL_W-1:0] RST_SEL = 16'h0000;
    localparam logic [POS_W-1:0] RST_POS = 32'h0000_0000;

    typedef enum logic [1:0] {
        SMON_LATCH_IDLE = 2'b01,
        SMON_LATCH_HELD = 2'b10
    } smon_latch_state_t;

endpackage : smon_pkg

/* File: inc/smon_quant_if.sv */
// quantities offered to the option monitor selectors
interface smon_quant_if;
    import smon_pkg::*;

    logic [WIDE_W-1:0] pos_deviation;
    logic [WIDE_W-1:0] pg_count;
    logic [POS_W-1:0] pulse_speed;
    logic [POS_W-1:0] cmd_pulse_cnt;
    logic [POS_W-1:0] fb_pulse_cnt;
    logic [POS_W-1:0] prev_latched_pos;

    modport prov (
        output pos_deviation,
        output pg_count,
        output pulse_speed,
        output cmd_pulse_cnt,
        output fb_pulse_cnt,
        output prev_latched_pos
    );

    modport sel (
        input pos_deviation,
        input pg_count,
        input pulse_speed,
        input cmd_pulse_cnt,
        input fb_pulse_cnt,
        input prev_latched_pos
    );

endinterface : smon_quant_if

/* File: src/smon_opt_mux.sv */
// second-level option monitor selector
module smon_opt_mux
    import smon_pkg::*;
(
    input wire logic [SEL_W-1:0] i_select,
    smon_quant_if.sel q,
    output logic [POS_W-1:0] o_value
);

    // ========================================================
    // saturate wide deviation into one word
    function automatic logic [POS_W-1:0] sat_word(input logic [WIDE_W-1:0] v);
        logic [POS_W-1:0] r;
        r = v[POS_W-1:0];
        if (v[WIDE_W-1] && !(&v[WIDE_W-1:POS_W-1])) begin
            r = {1'b1, {(POS_W-1){1'b0}}};
        end else if (!v[WIDE_W-1] && (|v[WIDE_W-1:POS_W-1])) begin
            r = {1'b0, {(POS_W-1){1'b1}}};
        end
        return r;
    endfunction

    // ========================================================
    // selection decode
    always_comb begin
        case (i_select)
            SEL_DEV_LO: o_value = q.pos_deviation[POS_W-1:0]; // RL8
            SEL_DEV_HI: o_value = q.pos_deviation[WIDE_W-1:POS_W]; // RL8
            SEL_PG_LO: o_value = q.pg_count[POS_W-1:0]; // RL9
            SEL_PG_HI: o_value = q.pg_count[WIDE_W-1:POS_W]; // RL9
            SEL_PULSE_SPD: o_value = q.pulse_speed; // RL10
            SEL_DEV_32: o_value = sat_word(q.pos_deviation); // RL10
            SEL_CMD_CNT: o_value = q.cmd_pulse_cnt; // RL10
            SEL_FB_CNT: o_value = q.fb_pulse_cnt; // RL10
            SEL_PREV_LATCH: o_value = q.prev_latched_pos; // RL11
            default: o_value = RST_POS; // RL13
        endcase
    end

endmodule // smon_opt_mux

/* File: src/smon_fb_pos.sv */
// machine-frame feedback position with backlash removed
module smon_fb_pos
    import smon_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [POS_W-1:0] i_shaft_pos,
    input wire logic [POS_W-1:0] i_backlash_amount,
    input wire logic i_backlash_active,
    output logic [POS_W-1:0] o_machine_feedback_pos,
    output logic o_backlash_applied
);

    logic [POS_W-1:0] pos_reg;
    logic [POS_W-1:0] pos_next;
    logic applied_reg;
    logic applied_next;

    // ========================================================
    // next value
    always_comb begin
        applied_next = i_backlash_active;
        if (i_backlash_active) begin
            pos_next = i_shaft_pos - i_backlash_amount; // RL12 RL5
        end else begin
            pos_next = i_shaft_pos; // RL12
        end
    end

    // ========================================================
    // registers
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pos_reg <= RST_POS;
            applied_reg <= 1'b0;
        end else begin
            pos_reg <= pos_next;
            applied_reg <= applied_next;
        end
    end

    assign o_machine_feedback_pos = pos_reg;
    assign o_backlash_applied = applied_reg;

endmodule // smon_fb_pos

/* File: tb/smon_selector_assertions.sv */
// concurrent checks on the monitor selector ports
module smon_selector_assertions
    import smon_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cfg_we,
    input wire logic [POS_W-1:0] i_cmd_pos_filtered,
    input wire logic [POS_W-1:0] i_cmd_pos_internal,
    input wire logic [POS_W-1:0] i_cmd_pos_unfiltered,
    input wire logic [POS_W-1:0] i_target_pos,
    input wire logic [WIDE_W-1:0] i_pos_deviation,
    input wire logic [POS_W-1:0] i_shaft_pos,
    input wire logic [POS_W-1:0] i_backlash_amount,
    input wire logic i_backlash_active,
    input wire logic [WIDE_W-1:0] i_pg_count,
    input wire logic [POS_W-1:0] i_pulse_speed,
    input wire logic [POS_W-1:0] i_cmd_pulse_cnt,
    input wire logic [POS_W-1:0] i_fb_pulse_cnt,
    input wire logic i_latch_pin,
    input wire logic i_latch_ack,
    input wire logic [SLOT_N-1:0][POS_W-1:0] o_monitor,
    input wire logic [POS_W-1:0] o_option_monitor_a,
    input wire logic [POS_W-1:0] o_option_monitor_b,
    input wire logic o_latch_done,
    input wire logic o_backlash_applied
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int IN_W = 9*POS_W+2*WIDE_W+3;
    // ========================================
    // quiet span counter
    logic [IN_W-1:0] in_now;
    logic [IN_W-1:0] in_reg;
    logic [2:0] quiet_reg;
    logic [2:0] quiet_next;
    assign in_now = {i_cfg_we, i_cmd_pos_filtered, i_cmd_pos_internal, i_cmd_pos_unfiltered,
        i_target_pos, i_pos_deviation, i_shaft_pos, i_backlash_amount, i_backlash_active,
        i_pg_count, i_pulse_speed, i_cmd_pulse_cnt, i_fb_pulse_cnt, i_latch_pin};
    always_comb begin
        quiet_next = (quiet_reg == 3'h7) ? 3'h7 : quiet_reg + 3'h1;
        if (in_now != in_reg) begin
            quiet_next = 3'h0;
        end
    end
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            quiet_reg <= 3'h0;
            in_reg <= '0;
        end else begin
            quiet_reg <= quiet_next;
            in_reg <= in_now;
        end
    end
    // ========================================
    // properties
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    chk_reset_zero: assert property ($past(i_rst) |-> o_monitor == '0 && !o_latch_done
        && o_option_monitor_a == '0 && o_option_monitor_b == '0) else $error("outputs not zero");
    chk_backlash_copy: assert property (!$past(i_rst) |->
        o_backlash_applied == $past(i_backlash_active)) else $error("backlash flag wrong");
    chk_latch_rise: assert property ($rose(i_latch_pin) && !i_latch_ack |->
        ##[1:4] o_latch_done) else $error("latch not reported");
    chk_done_cause: assert property ($rose(o_latch_done) |->
        $past(i_latch_pin, 2) || $past(i_latch_pin, 3)) else $error("latch without pin");
    chk_done_hold: assert property (o_latch_done && !i_latch_ack |=> o_latch_done)
        else $error("latch flag dropped");
    chk_ack_clear: assert property (o_latch_done && i_latch_ack && !i_latch_pin
        && !$past(i_latch_pin) && !$past(i_latch_pin, 2) && !$past(i_latch_pin, 3)
        |=> !o_latch_done) else $error("ack ignored");
    chk_monitor_stable: assert property (quiet_reg >= 3'h6 |-> $stable(o_monitor))
        else $error("monitor moved while quiet");
    chk_option_stable: assert property (quiet_reg >= 3'h6 |->
        $stable(o_option_monitor_a) && $stable(o_option_monitor_b)) else $error("option moved");
endmodule // smon_selector_assertions

/* File: tb/smon_host_model.sv */
// host side writer of slot codes and option selects
module smon_host_model
    import smon_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [15:0] i_codes,
    input wire logic [SEL_W-1:0] i_sel_a,
    input wire logic [SEL_W-1:0] i_sel_b,
    output logic o_cfg_we,
    output logic [15:0] o_codes,
    output logic [SEL_W-1:0] o_sel_a,
    output logic [SEL_W-1:0] o_sel_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // lines toggle when not written so stale values are never mistaken for writes
    always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_we <= 1'b0;
        end else if (i_go) begin
            o_cfg_we <= 1'b1;
            o_codes <= i_codes;
            o_sel_a <= i_sel_a;
            o_sel_b <= i_sel_b;
        end else begin
            o_cfg_we <= 1'b0;
            o_codes <= ~o_codes;
            o_sel_a <= ~o_sel_a;
            o_sel_b <= ~o_sel_b;
        end
    end
endmodule // smon_host_model

/* File: tb/testbench.sv */
// self-checking bench of the monitor selector
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import smon_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic [15:0] rc = 16'h0000;
    logic [SEL_W-1:0] ra = 16'h0000;
    logic [SEL_W-1:0] rb = 16'h0000;
    logic we;
    logic [15:0] codes;
    logic [SEL_W-1:0] sa;
    logic [SEL_W-1:0] sb;
    logic [POS_W-1:0] filt = 32'h1111_0000;
    logic [POS_W-1:0] intp = 32'h2222_0001;
    logic [POS_W-1:0] unf = 32'h5555_0005;
    logic [POS_W-1:0] tgt = 32'h6666_0006;
    logic [WIDE_W-1:0] dev = 64'h0000_0001_2345_6789;
    logic [POS_W-1:0] shaft = 32'h0000_3000;
    logic [POS_W-1:0] amt = 32'h0000_0100;
    logic act = 1'b1;
    logic [WIDE_W-1:0] pg = 64'hAAAA_0001_BBBB_0002;
    logic [POS_W-1:0] spd = 32'h0000_0017;
    logic [POS_W-1:0] ccnt = 32'h0000_001C;
    logic [POS_W-1:0] fcnt = 32'h0000_001D;
    logic pin = 1'b0;
    logic ack = 1'b0;
    logic [SLOT_N-1:0][POS_W-1:0] mon;
    logic [POS_W-1:0] oa;
    logic [POS_W-1:0] ob;
    logic done;
    logic bl;
    logic [POS_W-1:0] lat_exp = 32'h0;
    logic [POS_W-1:0] prev_exp = 32'h0;
    int bad_count = 0;
    int total_checks = 0;
    logic [47:0] rows [6] = '{{16'h3650, 16'h0003, 16'h0004}, {16'h21FE, 16'h000A, 16'h000B},
        {16'hD7FE, 16'h0017, 16'h0018}, {16'h98FE, 16'h001C, 16'h001D},
        {16'h00FE, 16'h0080, 16'h0005}, {16'hCBA4, 16'h0000, 16'hFFFF}};
    initial begin
        forever #12.5 clk = ~clk;
    end
    smon_host_model smon_host_model_inst (.i_ref_clk(clk), .i_rst(rst), .i_go(go),
        .i_codes(rc), .i_sel_a(ra), .i_sel_b(rb), .o_cfg_we(we), .o_codes(codes),
        .o_sel_a(sa), .o_sel_b(sb));
    smon_selector smon_selector_inst (.i_ref_clk(clk), .i_rst(rst), .i_cfg_we(we),
        .i_slot_code(codes), .i_option_monitor_a_select(sa), .i_option_monitor_b_select(sb),
        .i_cmd_pos_filtered(filt), .i_cmd_pos_internal(intp), .i_cmd_pos_unfiltered(unf),
        .i_target_pos(tgt), .i_pos_deviation(dev), .i_shaft_pos(shaft),
        .i_backlash_amount(amt), .i_backlash_active(act), .i_pg_count(pg),
        .i_pulse_speed(spd), .i_cmd_pulse_cnt(ccnt), .i_fb_pulse_cnt(fcnt),
        .i_latch_pin(pin), .i_latch_ack(ack), .o_monitor(mon), .o_option_monitor_a(oa),
        .o_option_monitor_b(ob), .o_latch_done(done), .o_backlash_applied(bl));
    // ========================================
    // expectations
    function automatic logic [POS_W-1:0] exp_sel(input logic [SEL_W-1:0] s);
        case (s)
            16'h0003: return dev[31:0];
            16'h0004: return dev[63:32];
            16'h000A: return pg[31:0];
            16'h000B: return pg[63:32];
            16'h0017: return spd;
            16'h0018: return ($signed(dev) > 64'sh7FFF_FFFF) ? 32'h7FFF_FFFF : dev[31:0];
            16'h001C: return ccnt;
            16'h001D: return fcnt;
            16'h0080: return prev_exp;
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic [POS_W-1:0] exp_code(input logic [3:0] c);
        case (c)
            4'h0: return filt;
            4'h1: return intp;
            4'h2: return dev[31:0];
            4'h3: return act ? shaft - amt : shaft;
            4'h4: return lat_exp;
            4'h5: return unf;
            4'h6: return tgt;
            4'hE: return exp_sel(ra);
            4'hF: return exp_sel(rb);
            default: return 32'h0;
        endcase
    endfunction
    // ========================================
    // shared tasks
    task automatic chk(input string nm, input logic [POS_W-1:0] e, input logic [POS_W-1:0] g);
        total_checks++;
        if (e !== g) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apply(input logic [47:0] r);
        @(posedge clk);
        go <= 1'b1;
        {rc, ra, rb} <= r;
        @(posedge clk);
        go <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        for (int s = 0; s < SLOT_N; s++) begin
            chk("monitor", exp_code(rc[4*s+:4]), mon[s]);
        end
        chk("option_a", exp_sel(ra), oa);
        chk("option_b", exp_sel(rb), ob);
        chk("backlash_flag", {31'h0, act}, {31'h0, bl});
        @(posedge clk);
    endtask
    task automatic latch_pulse();
        @(posedge clk);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("latch_done", 32'h1, {31'h0, done});
        prev_exp = lat_exp;
        lat_exp = act ? shaft - amt : shaft;
        @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(25 * 4000);
        bad_count++;
        end_of_test();
    end
    // ========================================
    // main sequence
    initial begin
        repeat (11) @(posedge clk);
        @(negedge clk);
        chk("reset_monitor", 32'h0, mon[0] | mon[1] | mon[2] | mon[3] | oa | ob);
        @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            apply(rows[i]);
        end
        $display("table done");
        act <= 1'b0;
        apply(rows[0]);
        act <= 1'b1;
        shaft <= 32'h0000_0180;
        apply(rows[0]);
        $display("backlash done");
        apply({16'hFE34, 16'h0080, 16'h0018});
        latch_pulse();
        apply({16'hFE34, 16'h0080, 16'h0018});
        shaft <= 32'h0000_4000;
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        @(negedge clk);
        chk("latch_ack", 32'h0, {31'h0, done});
        latch_pulse();
        apply({16'hFE34, 16'h0080, 16'h0018});
        $display("latch done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("mid_reset", 32'h0, mon[0] | mon[1] | mon[2] | mon[3] | {31'h0, done});
        lat_exp = 32'h0;
        prev_exp = 32'h0;
        @(posedge clk);
        rst <= 1'b0;
        apply({16'hFE04, 16'h0080, 16'h0004});
        $display("reset done");
        end_of_test();
    end
endmodule // testbench
bind smon_selector smon_selector_assertions smon_selector_assertions_inst (.*);
